// ---- include/atou_pkg.sv ----
// package: register map, reset values and bus types of the alert output block
package atou_pkg;

    localparam int          ATOU_ADDR_W      = 8;
    localparam int          ATOU_DATA_W      = 8;
    localparam int          ATOU_NUM_CH      = 8;
    localparam int          ATOU_NUM_OUT     = 8;

    // register byte addresses
    localparam logic [7:0]  ATOU_OFS_SRC0    = 8'hc3;
    localparam logic [7:0]  ATOU_OFS_SRC1    = 8'hc5;
    localparam logic [7:0]  ATOU_OFS_SRC2    = 8'hc7;
    localparam logic [7:0]  ATOU_OFS_SRC3    = 8'hc9;
    localparam logic [7:0]  ATOU_OFS_SRC4    = 8'hcb;
    localparam logic [7:0]  ATOU_OFS_SRC5    = 8'hcd;
    localparam logic [7:0]  ATOU_OFS_SRC6    = 8'hcf;
    localparam logic [7:0]  ATOU_OFS_SRC7    = 8'hd1;
    localparam logic [7:0]  ATOU_OFS_UPD_EN  = 8'he9;
    localparam logic [7:0]  ATOU_OFS_LEVEL   = 8'heb;
    localparam logic [7:0]  ATOU_OFS_OUTVAL  = 8'hf0;

    // reset values
    localparam logic [7:0]  ATOU_RST_SRC     = 8'h02;
    localparam logic [7:0]  ATOU_RST_UPD_EN  = 8'h00;
    localparam logic [7:0]  ATOU_RST_LEVEL   = 8'h00;
    localparam logic [7:0]  ATOU_RST_OUT     = 8'h00;

    localparam logic [31:0] ATOU_UNMAPPED    = 32'h00000000;

    // avalon request from the master
    typedef struct packed {
        logic [ATOU_ADDR_W-1:0] address;
        logic                   read;
        logic                   write;
        logic [31:0]            writedata;
        logic [3:0]             byteenable;
    } atou_av_req_t;

    // avalon answer to the master
    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } atou_av_rsp_t;

endpackage : atou_pkg

// ---- src/atou_alert_output.sv ----
// module: alert-triggered update of the eight digital outputs
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps

module atou_alert_output
    import atou_pkg::*;
(
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rstn,
    // register bus
    input  wire atou_av_req_t            av_req,
    output atou_av_rsp_t                 av_rsp,
    // alert flags per channel, same clock domain
    input  wire logic [ATOU_NUM_CH-1:0]  alert_flags,
    // digital outputs
    output logic      [ATOU_NUM_OUT-1:0] digital_output_pin
);

    logic [ATOU_NUM_CH-1:0]  src_mask      [ATOU_NUM_OUT];
    logic [ATOU_NUM_CH-1:0]  next_src_mask [ATOU_NUM_OUT];
    logic [ATOU_NUM_OUT-1:0] update_en;
    logic [ATOU_NUM_OUT-1:0] next_update_en;
    logic [ATOU_NUM_OUT-1:0] level_vals;
    logic [ATOU_NUM_OUT-1:0] next_level_vals;
    logic [ATOU_NUM_OUT-1:0] out_q;
    logic [ATOU_NUM_OUT-1:0] next_out_q;
    logic [ATOU_NUM_OUT-1:0] trig_now;
    logic [ATOU_NUM_OUT-1:0] trig_prev;
    logic [ATOU_NUM_OUT-1:0] next_trig_prev;
    logic [ATOU_NUM_OUT-1:0] src_hit;
    logic                    en_hit;
    logic                    lvl_hit;
    logic                    outval_hit;
    logic                    req_any;
    logic [ATOU_NUM_OUT-1:0] trig_rise;
    logic [31:0]             rdata;
    logic [31:0]             next_rdata;
    logic                    wait_q;
    logic                    next_wait_q;
    logic                    acc;
    logic                    wr_ok;
    logic [7:0]              wbyte;
    logic [7:0]              rbyte;

    localparam logic [7:0] SRC_OFS [ATOU_NUM_OUT] = '{
        ATOU_OFS_SRC0, ATOU_OFS_SRC1, ATOU_OFS_SRC2, ATOU_OFS_SRC3,
        ATOU_OFS_SRC4, ATOU_OFS_SRC5, ATOU_OFS_SRC6, ATOU_OFS_SRC7};

    // one wait cycle per access: the request is taken while waitrequest is
    // high and answered in the next cycle
    assign req_any = av_req.read | av_req.write;
    assign acc     = req_any & wait_q;
    // a write lands at the edge where the master sees waitrequest low, so a
    // request withdrawn before its answer never alters a register
    assign wr_ok   = av_req.write & ~wait_q & av_req.byteenable[0];
    assign wbyte   = av_req.writedata[7:0];

    // address decode shared by the write and read paths
    always_comb
    begin
        en_hit     = 1'b0;
        lvl_hit    = 1'b0;
        outval_hit = 1'b0;
        if (av_req.address == ATOU_OFS_UPD_EN)
        begin
            en_hit = 1'b1;
        end
        else if (av_req.address == ATOU_OFS_LEVEL)
        begin
            lvl_hit = 1'b1;
        end
        else if (av_req.address == ATOU_OFS_OUTVAL)
        begin
            outval_hit = 1'b1;
        end
    end

    // trigger per output: OR of the alert flags its mask selects
    genvar gn;
    generate
        for (gn = 0; gn < ATOU_NUM_OUT; gn++)
        begin : g_out
            assign src_hit[gn]  = (av_req.address == SRC_OFS[gn]);
            // cleared bits drop out of the OR
            assign trig_now[gn] = |(alert_flags & src_mask[gn]);
            always_comb
            begin
                next_src_mask[gn] = src_mask[gn];
                if (wr_ok && src_hit[gn])
                begin
                    next_src_mask[gn] = wbyte;
                end
            end
            always_ff @(posedge clk)
            begin
                if (!rstn)
                begin
                    src_mask[gn] <= ATOU_RST_SRC;
                end
                else
                begin
                    src_mask[gn] <= next_src_mask[gn];
                end
            end
        end
    endgenerate

    // a rise is seen against last cycle's trigger, so a flag that stays set
    // does not keep overwriting the output after software changes the level
    assign trig_rise = trig_now & ~trig_prev;

    always_comb
    begin
        next_update_en  = update_en;
        next_level_vals = level_vals;
        if (wr_ok && en_hit)
        begin
            next_update_en = wbyte;
        end
        if (wr_ok && lvl_hit)
        begin
            next_level_vals = wbyte;
        end
    end

    always_comb
    begin
        next_out_q = out_q;
        for (int n = 0; n < ATOU_NUM_OUT; n++)
        begin
            if (trig_rise[n] && update_en[n])
            begin
                next_out_q[n] = level_vals[n];
            end
        end
    end

    // read mux
    always_comb
    begin
        rbyte = 8'h00;
        if (en_hit)
        begin
            rbyte = update_en;
        end
        else if (lvl_hit)
        begin
            rbyte = level_vals;
        end
        else if (outval_hit)
        begin
            rbyte = out_q;
        end
        else if (src_hit[0])
        begin
            rbyte = src_mask[0];
        end
        else if (src_hit[1])
        begin
            rbyte = src_mask[1];
        end
        else if (src_hit[2])
        begin
            rbyte = src_mask[2];
        end
        else if (src_hit[3])
        begin
            rbyte = src_mask[3];
        end
        else if (src_hit[4])
        begin
            rbyte = src_mask[4];
        end
        else if (src_hit[5])
        begin
            rbyte = src_mask[5];
        end
        else if (src_hit[6])
        begin
            rbyte = src_mask[6];
        end
        else if (src_hit[7])
        begin
            rbyte = src_mask[7];
        end
    end

    always_comb
    begin
        next_wait_q = 1'b1;
        next_rdata  = rdata;
        if (acc)
        begin
            next_wait_q = 1'b0;
            next_rdata  = ATOU_UNMAPPED;
            if (av_req.read)
            begin
                next_rdata = {24'h000000, rbyte};
            end
        end
    end

    // configuration registers
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            update_en  <= ATOU_RST_UPD_EN;
            level_vals <= ATOU_RST_LEVEL;
        end
        else
        begin
            update_en  <= next_update_en;
            level_vals <= next_level_vals;
        end
    end

    // trigger history: a flag already high at reset release still counts as
    // a rise, but every output is disabled then, so nothing moves
    always_comb
    begin
        next_trig_prev = trig_now;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            trig_prev <= '0;
        end
        else
        begin
            trig_prev <= next_trig_prev;
        end
    end

    // output levels
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            out_q <= ATOU_RST_OUT;
        end
        else
        begin
            out_q <= next_out_q;
        end
    end

    // bus answer
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            rdata  <= ATOU_UNMAPPED;
            wait_q <= 1'b1;
        end
        else
        begin
            rdata  <= next_rdata;
            wait_q <= next_wait_q;
        end
    end

    assign av_rsp.readdata    = rdata;
    assign av_rsp.waitrequest = wait_q;
    assign digital_output_pin = out_q;

endmodule : atou_alert_output

// ---- test/atou_alert_output_assertions.sv ----
// checker: bus answer, readback and alert output assertions
`timescale 1ns/10ps
module atou_alert_output_chk
    import atou_pkg::*;
(
    // clock and reset
    input wire logic         clk,
    input wire logic         rstn,
    // bus and pins
    input wire atou_av_req_t av_req,
    input wire atou_av_rsp_t av_rsp,
    input wire logic [7:0]   alert_flags,
    input wire logic [7:0]   digital_output_pin
);
    logic [7:0] en_q, lvl_q, flg_q;
    logic       wr;
    assign wr = av_req.write && !av_rsp.waitrequest && av_req.byteenable[0];
    // shadows of the enable and level registers the pins depend on
    always_ff @(posedge clk)
    begin
        flg_q <= alert_flags;
        en_q  <= !rstn ? 8'h00 : (wr && av_req.address == ATOU_OFS_UPD_EN)
                 ? av_req.writedata[7:0] : en_q;
        lvl_q <= !rstn ? 8'h00 : (wr && av_req.address == ATOU_OFS_LEVEL)
                 ? av_req.writedata[7:0] : lvl_q;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence taken_s;
        (av_req.read || av_req.write) && av_rsp.waitrequest;
    endsequence
    sequence answer_s;
        !av_rsp.waitrequest ##1 av_rsp.waitrequest;
    endsequence
    bus_answer_a: assert property (taken_s |=> answer_s)
        else $error("request not answered in one cycle");
    idle_wait_a: assert property (!av_req.read && !av_req.write
        |=> av_rsp.waitrequest) else $error("answer without request");
    read_upper_a: assert property (!av_rsp.waitrequest
        |-> av_rsp.readdata[31:8] == 24'h0) else $error("upper bits set");
    en_read_a: assert property (!av_rsp.waitrequest && $past(av_req.read)
        && av_req.address == ATOU_OFS_UPD_EN |-> av_rsp.readdata[7:0] == en_q)
        else $error("enable readback wrong");
    lvl_read_a: assert property (!av_rsp.waitrequest && $past(av_req.read)
        && av_req.address == ATOU_OFS_LEVEL |-> av_rsp.readdata[7:0] == lvl_q)
        else $error("level readback wrong");
    quiet_out_a: assert property (!(|(alert_flags & ~flg_q))
        && !av_req.write && !$past(av_req.write)
        |=> $stable(digital_output_pin))
        else $error("output moved without a rising flag");
    dis_out_a: assert property ($past(rstn) |-> ((digital_output_pin ^
        $past(digital_output_pin)) & ~$past(en_q)) == 8'h0)
        else $error("disabled output changed");
    lvl_out_a: assert property ($past(rstn) |-> ((digital_output_pin ^
        $past(digital_output_pin)) & (digital_output_pin ^ $past(lvl_q)))
        == 8'h0) else $error("output took wrong level");
endmodule : atou_alert_output_chk
bind atou_alert_output atou_alert_output_chk atou_alert_output_chk_inst (
    .clk(clk), .rstn(rstn), .av_req(av_req), .av_rsp(av_rsp),
    .alert_flags(alert_flags), .digital_output_pin(digital_output_pin));

// ---- test/test_atou_alert_output.sv ----
// bench: register access and alert-triggered output updates
`timescale 1ns/10ps
module test_atou_alert_output
    import atou_pkg::*;
;
    logic         clk, rstn;
    atou_av_req_t req;
    atou_av_rsp_t rsp;
    logic [7:0]   flags, pin;
    logic [31:0]  q;
    int           n_mismatch, samples_checked, cyc;
    atou_alert_output atou_alert_output_inst (.clk(clk), .rstn(rstn),
        .av_req(req), .av_rsp(rsp), .alert_flags(flags),
        .digital_output_pin(pin));
    initial
    begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    // the whole run needs fewer than a hundred cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // no wait bound here: the cycle counter cuts a hung bus
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        req.address <= a;
        req.read <= !w;
        req.write <= w;
        req.writedata <= {24'h0, d};
        do @(posedge clk); while (rsp.waitrequest !== 1'b0);
        q = rsp.readdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask : bus
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        bus(0, a, 8'h0);
        chk(q, {24'h0, e});
    endtask : rchk
    task automatic edge_chk(input logic [7:0] f, input logic [7:0] e);
        @(posedge clk);
        flags <= f;
        @(posedge clk);
        #1 chk(pin, e);
    endtask : edge_chk
    task automatic t_reset();
        rchk(ATOU_OFS_SRC5, 8'h02);
        rchk(ATOU_OFS_SRC6, 8'h02);
        rchk(ATOU_OFS_SRC7, 8'h02);
        rchk(ATOU_OFS_UPD_EN, 8'h00);
        rchk(ATOU_OFS_LEVEL, 8'h00);
        rchk(8'h10, 8'h00);
        chk(pin, 32'h0);
    endtask : t_reset
    task automatic t_select();
        bus(1, ATOU_OFS_SRC5, 8'h80);
        bus(1, ATOU_OFS_SRC7, 8'h00);
        bus(1, ATOU_OFS_UPD_EN, 8'he0);
        bus(1, ATOU_OFS_LEVEL, 8'he0);
        rchk(ATOU_OFS_SRC5, 8'h80);
        rchk(ATOU_OFS_LEVEL, 8'he0);
        edge_chk(8'h80, 8'h20);
        edge_chk(8'h82, 8'h60);
        bus(1, ATOU_OFS_LEVEL, 8'h00);
        edge_chk(8'h82, 8'h60);
        edge_chk(8'h00, 8'h60);
        edge_chk(8'h02, 8'h20);
    endtask : t_select
    task automatic t_disable();
        bus(1, ATOU_OFS_UPD_EN, 8'h00);
        bus(1, ATOU_OFS_LEVEL, 8'hff);
        edge_chk(8'h00, 8'h20);
        edge_chk(8'h82, 8'h20);
        rchk(ATOU_OFS_OUTVAL, 8'h20);
        req.byteenable <= 4'h0;
        bus(1, ATOU_OFS_LEVEL, 8'h00);
        req.byteenable <= 4'hf;
        rchk(ATOU_OFS_LEVEL, 8'hff);
    endtask : t_disable
    initial
    begin
        req = '0;
        req.byteenable = 4'hf;
        flags = 8'h0;
        rstn = 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_select();
        t_disable();
        summarize();
    end
endmodule : test_atou_alert_output
